// ### dbg_host.sv
// debugger bus master and power controller model for the debug port
`timescale 1ns/100ps
module dbg_host (
   // clock
   input wire logic clk,
   // apb master side
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [9:0] paddr = 10'h000,
   output logic [31:0] pwdata = 32'h0,
   output logic access_source_bit = 1'b0,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // halt and power lines
   output logic ext_halt_request = 1'b0,
   input wire logic halt_acknowledge,
   output logic core_powerdown_request = 1'b0
);
   // ****
   // transfers, called just after a rising edge
   // ****
   task xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e, output logic ok);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      access_source_bit <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      q = prdata;
      e = pslverr;
      ok = (n < 8);
      psel <= 1'b0;
      penable <= 1'b0;
      // inverted leftovers so stale bus values never look valid
      paddr <= ~a;
      pwdata <= ~d;
      // one idle edge, so a following call never re-raises psel at once
      @(posedge clk);
   endtask
   // request held until acknowledged, or dropped after 30 edges without acknowledge
   task halt(output logic ok);
      int n;
      ext_halt_request <= 1'b1;
      n = 0;
      while (halt_acknowledge !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      ext_halt_request <= 1'b0;
      ok = (n < 30);
   endtask
   // raised ahead of any core supply removal
   task pwr(input logic v);
      core_powerdown_request <= v;
   endtask
endmodule

// ### debug_cache_policy.sv
// debug-state cache allocation, write policy and maintenance checks
`timescale 1ns/100ps
`include "debug_ext_params.svh"
module debug_cache_policy (
   // state and control
   input wire logic in_debug,
   input wire logic [2:0] cache_ctrl,
   // data access
   input wire logic acc_write,
   input wire logic acc_hit,
   input wire logic acc_alias12,
   input wire logic acc_hash_match,
   output logic linefill_en,
   output logic evict_en,
   output logic write_through,
   output logic write_to_poc,
   // maintenance operation
   input wire logic op_valid,
   input wire debug_ext_pkg::cache_op_t op_code,
   input wire logic op_privileged,
   input wire logic op_nonsecure,
   output logic op_accept,
   output logic op_undef,
   output logic op_nop,
   output logic op_flush_both
);
   logic no_pollute;
   logic wt_forced;
   // pollution and write-through policy
   always_comb begin
      no_pollute = in_debug && !cache_ctrl[`CC_POLLUTE];
      wt_forced = in_debug && !cache_ctrl[`CC_NO_WT];
      linefill_en = !no_pollute;
      // aliases and hash twins still push the line out to level two
      evict_en = !no_pollute || acc_alias12 || acc_hash_match;
      write_through = wt_forced && acc_hit;
      write_to_poc = wt_forced && acc_write;
   end
   // maintenance permission: debug state overrides privilege checks for instruction cache and branch predictor ops
   always_comb begin
      unique case (op_code)
         debug_ext_pkg::OP_ICACHE_INV_ALL,
         debug_ext_pkg::OP_ICACHE_INV_LINE:
            op_accept = op_valid && (op_privileged || in_debug);
         debug_ext_pkg::OP_BTB_FLUSH:
            op_accept = op_valid && (op_privileged || in_debug);
         debug_ext_pkg::OP_OTHER:
            op_accept = op_valid && op_privileged;
      endcase
      op_undef = op_valid && !op_accept;
      // branch predictor flush has no effect beyond being accepted
      op_nop = op_accept && (op_code == debug_ext_pkg::OP_BTB_FLUSH);
      op_flush_both = op_accept && op_nonsecure
         && (op_code == debug_ext_pkg::OP_ICACHE_INV_ALL);
   end
endmodule

// ### debug_ext_params.svh
// offsets, field positions and reset values of the debug port block
`ifndef DEBUG_EXT_PARAMS_SVH
`define DEBUG_EXT_PARAMS_SVH
// word index on paddr, which carries byte address bits 11:2
`define IDX_STATUS 10'h000
`define IDX_CACHE_CTRL 10'h001
`define IDX_RX_DATA 10'h002
`define IDX_TX_DATA 10'h003
`define IDX_PWR_CTRL 10'h004
`define IDX_PWR_STATUS 10'h005
`define IDX_OSLOCK 10'h006
`define IDX_ROM_ADDR 10'h007
`define IDX_SELF_ADDR 10'h008
`define IDX_RUN_CTRL 10'h009
// status word fields
`define BIT_HALTED 0
`define BIT_RESTARTED 1
`define ENTRY_LSB 2
`define ENTRY_MSB 5
`define BIT_ACK_FORCE 10
`define BIT_ACK_STICKY 11
`define BIT_TX_FULL 29
`define BIT_RX_FULL 30
`define BIT_SRC 31
// entry method codes
`define ENTRY_EXT_HALT 4'h4
`define ENTRY_SW_HALT 4'h0
// cache control fields and reset
`define CC_POLLUTE 0
`define CC_NO_WT 2
`define CC_RESET 3'h7
// run control fields
`define RUN_HALT 0
`define RUN_RESTART 1
// config address fields
`define CFG_ADDR_LSB 12
`define CFG_VALID 0
// edges after reset release during which straps are still captured
`define CFG_SETTLE 2'h3
`endif

// ### debug_ext_pkg.sv
// types shared by the debug port block
package debug_ext_pkg;
   // run / debug handshake states
   typedef enum logic [1:0] {RUN, HALTING, HALTED, EXITING} dbg_state_t;
   // cache maintenance operations seen by the policy logic
   typedef enum logic [1:0] {
      OP_ICACHE_INV_ALL,
      OP_ICACHE_INV_LINE,
      OP_BTB_FLUSH,
      OP_OTHER
   } cache_op_t;
endpackage

// ### debug_ext_port.sv
// debug slave port, halt handshake, channel, power and cache debug control
`timescale 1ns/100ps
`include "debug_ext_params.svh"
module debug_ext_port (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic access_source_bit,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // halt handshake
   input wire logic ext_halt_request,
   output logic halt_acknowledge,
   output logic core_halt_req,
   output logic core_restart,
   input wire logic core_in_debug,
   // communication channel, core side
   input wire logic core_rx_read,
   output logic [31:0] core_rx_data,
   input wire logic core_tx_write,
   input wire logic [31:0] core_tx_data,
   output logic chan_rx_irq,
   output logic chan_tx_irq,
   // power control
   input wire logic core_powerdown_request,
   input wire logic core_idle,
   output logic core_powerdown_ack,
   output logic keep_powered_out,
   // configuration straps
   input wire logic oslock_init_in,
   input wire logic [19:0] rom_base_addr,
   input wire logic rom_base_valid,
   input wire logic [19:0] self_offset_addr,
   input wire logic self_offset_valid,
   output logic oslock,
   // cache access from the load/store unit
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic acc_hit,
   input wire logic acc_alias12,
   input wire logic acc_hash_match,
   output logic cache_linefill_en,
   output logic cache_evict_en,
   output logic cache_write_through,
   output logic cache_write_to_poc,
   // cache maintenance operation
   input wire logic op_valid,
   input wire debug_ext_pkg::cache_op_t op_code,
   input wire logic op_privileged,
   input wire logic op_nonsecure,
   output logic op_accept,
   output logic op_undef,
   output logic op_nop,
   output logic op_flush_both
);
   // ****************************************
   // synchronised inputs
   // ****************************************
   logic halt_req_s, pd_req_s, oslock_init_s;
   debug_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({ext_halt_request, core_powerdown_request, oslock_init_in}),
      .q({halt_req_s, pd_req_s, oslock_init_s})
   );

   // ****************************************
   // apb slave
   // ****************************************
   // registered ready gives every transfer exactly one wait state
   function automatic logic is_mapped(input logic [9:0] idx);
      is_mapped = (idx <= `IDX_RUN_CTRL);
   endfunction

   logic xfer, wr, rd;
   logic [31:0] status_word, read_word;
   logic next_pready, next_pslverr;
   logic [31:0] next_prdata;
   assign xfer = psel && penable && !pready;
   assign wr = xfer && pwrite && is_mapped(paddr);
   assign rd = xfer && !pwrite && is_mapped(paddr);

   // ****************************************
   // register state
   // ****************************************
   debug_ext_pkg::dbg_state_t state, next_state;
   logic [3:0] entry_method, next_entry_method;
   logic ack_force, next_ack_force, ack_sticky, next_ack_sticky;
   logic restarted, next_restarted, src_last, next_src_last;
   logic ext_src, next_ext_src;
   logic [2:0] cache_ctrl, next_cache_ctrl;
   logic keep_powered, next_keep_powered;
   logic rx_full, next_rx_full, tx_full, next_tx_full;
   logic [31:0] rx_data, next_rx_data, tx_data, next_tx_data;
   logic cfg_done, next_oslock;
   logic [1:0] cfg_age, next_cfg_age;
   // straps must cross the synchroniser before they can be trusted
   assign cfg_done = (cfg_age == `CFG_SETTLE);
   logic [31:0] rom_word, next_rom_word, self_word, next_self_word;
   logic sw_halt, sw_restart, next_ack;

   assign sw_halt = wr && (paddr == `IDX_RUN_CTRL) && pwdata[`RUN_HALT];
   assign sw_restart = wr && (paddr == `IDX_RUN_CTRL)
      && pwdata[`RUN_RESTART];

   // status word and read mux
   always_comb begin
      status_word = 32'h0;
      status_word[`BIT_HALTED] = (state == debug_ext_pkg::HALTED);
      status_word[`BIT_RESTARTED] = restarted;
      status_word[`ENTRY_MSB:`ENTRY_LSB] = entry_method;
      status_word[`BIT_ACK_FORCE] = ack_force;
      status_word[`BIT_ACK_STICKY] = ack_sticky;
      status_word[`BIT_TX_FULL] = tx_full;
      status_word[`BIT_RX_FULL] = rx_full;
      status_word[`BIT_SRC] = src_last;
      unique case (paddr)
         `IDX_STATUS: read_word = status_word;
         `IDX_CACHE_CTRL: read_word = {29'h0, cache_ctrl};
         `IDX_RX_DATA: read_word = rx_data;
         `IDX_TX_DATA: read_word = tx_data;
         `IDX_PWR_CTRL: read_word = {31'h0, keep_powered};
         `IDX_PWR_STATUS: read_word = {31'h0, pd_req_s};
         `IDX_OSLOCK: read_word = {31'h0, oslock};
         `IDX_ROM_ADDR: read_word = rom_word;
         `IDX_SELF_ADDR: read_word = self_word;
         default: read_word = 32'h0;
      endcase
   end

   // bus answer: unmapped words answer with an error and zero data
   always_comb begin
      next_pready = xfer;
      next_pslverr = xfer && !is_mapped(paddr);
      next_prdata = rd ? read_word : 32'h0;
   end

   // handshake state machine with the core
   always_comb begin
      next_state = state;
      next_entry_method = entry_method;
      next_ext_src = ext_src;
      next_restarted = restarted;
      unique case (state)
         debug_ext_pkg::RUN: begin
            if (halt_req_s || sw_halt) begin
               next_state = debug_ext_pkg::HALTING;
               next_ext_src = halt_req_s;
            end
         end
         debug_ext_pkg::HALTING: begin
            // no abort: HALTING waits for core_in_debug even if the request drops
            if (core_in_debug) begin
               next_state = debug_ext_pkg::HALTED;
               next_entry_method = ext_src ? `ENTRY_EXT_HALT
                  : `ENTRY_SW_HALT;
            end
         end
         debug_ext_pkg::HALTED: begin
            if (sw_restart) begin
               next_state = debug_ext_pkg::EXITING;
               next_restarted = 1'b0;
            end
         end
         debug_ext_pkg::EXITING: begin
            if (!core_in_debug) begin
               next_state = debug_ext_pkg::RUN;
               next_restarted = 1'b1;
            end
         end
      endcase
      // acknowledge: debug state, force bit, or held by the sticky bit
      next_ack = (next_state == debug_ext_pkg::HALTED)
         || next_ack_force
         || (halt_acknowledge && next_ack_sticky);
   end

   // software-written fields and channel flags
   always_comb begin
      next_ack_force = ack_force;
      next_ack_sticky = ack_sticky;
      next_src_last = xfer ? access_source_bit : src_last;
      next_cache_ctrl = cache_ctrl;
      next_keep_powered = keep_powered;
      next_rx_data = rx_data;
      next_tx_data = tx_data;
      next_oslock = oslock;
      if (wr && paddr == `IDX_STATUS) begin
         next_ack_force = pwdata[`BIT_ACK_FORCE];
         next_ack_sticky = pwdata[`BIT_ACK_STICKY];
      end
      if (wr && paddr == `IDX_CACHE_CTRL) begin
         next_cache_ctrl = pwdata[2:0];
      end
      if (wr && paddr == `IDX_PWR_CTRL) begin
         next_keep_powered = pwdata[0];
      end
      if (wr && paddr == `IDX_OSLOCK) begin
         next_oslock = pwdata[0];
      end
      // straps are caught until the synchroniser has filled after reset
      if (!cfg_done) begin
         next_oslock = oslock_init_s;
      end
      // a set in the same cycle as a clear wins
      next_rx_full = rx_full && !core_rx_read;
      if (wr && paddr == `IDX_RX_DATA) begin
         next_rx_data = pwdata;
         next_rx_full = 1'b1;
      end
      next_tx_full = tx_full && !(rd && paddr == `IDX_TX_DATA);
      if (core_tx_write) begin
         next_tx_data = core_tx_data;
         next_tx_full = 1'b1;
      end
   end

   // configuration words sampled after reset; inputs only move in reset
   always_comb begin
      next_cfg_age = cfg_done ? cfg_age : cfg_age + 2'h1;
      next_rom_word = rom_word;
      next_self_word = self_word;
      if (!cfg_done) begin
         next_rom_word = {rom_base_addr, 11'h0, rom_base_valid};
         next_self_word = {self_offset_addr, 11'h0, self_offset_valid};
      end
   end

   // ****************************************
   // cache policy
   // ****************************************
   logic p_fill, p_evict, p_wt, p_poc, p_acc, p_und, p_nop, p_both;
   debug_cache_policy u_policy (
      .in_debug(state == debug_ext_pkg::HALTED),
      .cache_ctrl(cache_ctrl),
      .acc_write(acc_write),
      .acc_hit(acc_hit),
      .acc_alias12(acc_alias12),
      .acc_hash_match(acc_hash_match),
      .linefill_en(p_fill),
      .evict_en(p_evict),
      .write_through(p_wt),
      .write_to_poc(p_poc),
      .op_valid(op_valid),
      .op_code(op_code),
      .op_privileged(op_privileged),
      .op_nonsecure(op_nonsecure),
      .op_accept(p_acc),
      .op_undef(p_und),
      .op_nop(p_nop),
      .op_flush_both(p_both)
   );

   // ****************************************
   // registers
   // ****************************************
   // all outputs leave from flops; policy answers one cycle after the ask
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= debug_ext_pkg::RUN;
         entry_method <= `ENTRY_SW_HALT;
         ext_src <= 1'b0;
         restarted <= 1'b0;
         ack_force <= 1'b0;
         ack_sticky <= 1'b0;
         src_last <= 1'b0;
         cache_ctrl <= `CC_RESET;
         keep_powered <= 1'b0;
         rx_full <= 1'b0;
         tx_full <= 1'b0;
         rx_data <= 32'h0;
         tx_data <= 32'h0;
         oslock <= 1'b0;
         cfg_age <= 2'h0;
         rom_word <= 32'h0;
         self_word <= 32'h0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         halt_acknowledge <= 1'b0;
         core_halt_req <= 1'b0;
         core_restart <= 1'b0;
         core_rx_data <= 32'h0;
         chan_rx_irq <= 1'b0;
         chan_tx_irq <= 1'b1;
         core_powerdown_ack <= 1'b0;
         keep_powered_out <= 1'b0;
         cache_linefill_en <= 1'b1;
         cache_evict_en <= 1'b1;
         cache_write_through <= 1'b0;
         cache_write_to_poc <= 1'b0;
         op_accept <= 1'b0;
         op_undef <= 1'b0;
         op_nop <= 1'b0;
         op_flush_both <= 1'b0;
      end else begin
         state <= next_state;
         entry_method <= next_entry_method;
         ext_src <= next_ext_src;
         restarted <= next_restarted;
         ack_force <= next_ack_force;
         ack_sticky <= next_ack_sticky;
         src_last <= next_src_last;
         cache_ctrl <= next_cache_ctrl;
         keep_powered <= next_keep_powered;
         rx_full <= next_rx_full;
         tx_full <= next_tx_full;
         rx_data <= next_rx_data;
         tx_data <= next_tx_data;
         oslock <= next_oslock;
         cfg_age <= next_cfg_age;
         rom_word <= next_rom_word;
         self_word <= next_self_word;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         halt_acknowledge <= next_ack;
         core_halt_req <= (next_state == debug_ext_pkg::HALTING);
         core_restart <= (next_state == debug_ext_pkg::EXITING);
         core_rx_data <= next_rx_data;
         chan_rx_irq <= next_rx_full;
         chan_tx_irq <= !next_tx_full;
         core_powerdown_ack <= pd_req_s && core_idle;
         keep_powered_out <= next_keep_powered;
         cache_linefill_en <= acc_valid && p_fill;
         cache_evict_en <= acc_valid && p_evict;
         cache_write_through <= acc_valid && p_wt;
         cache_write_to_poc <= acc_valid && p_poc;
         op_accept <= p_acc;
         op_undef <= p_und;
         op_nop <= p_nop;
         op_flush_both <= p_both;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic dbg;
   assign dbg = (state == debug_ext_pkg::HALTED);

   a_rx_irq_level: assert property (chan_rx_irq == rx_full)
      else $error("receive interrupt differs from receive-full flag");
   a_tx_irq_level: assert property (chan_tx_irq == !tx_full)
      else $error("transmit interrupt not inverse of transmit-full");
   a_ext_entry_code: assert property (
      state == debug_ext_pkg::HALTING && ext_src && core_in_debug
      |=> dbg && entry_method == `ENTRY_EXT_HALT)
      else $error("external halt entry code not loaded");
   a_ack_when_halted: assert property (dbg |-> halt_acknowledge)
      else $error("halted without acknowledge");
   a_ack_force_high: assert property (ack_force |-> halt_acknowledge)
      else $error("acknowledge force bit ignored");
   a_ack_exit_drop: assert property (
      state == debug_ext_pkg::RUN && $past(state) != debug_ext_pkg::RUN
      && !ack_sticky && !ack_force |-> !halt_acknowledge)
      else $error("acknowledge held after exit without sticky bit");
   a_no_pollution: assert property (
      dbg && !cache_ctrl[`CC_POLLUTE] && acc_valid && !acc_alias12
      && !acc_hash_match |=> !cache_linefill_en && !cache_evict_en)
      else $error("cache allocated while pollution suppressed");
   a_alias_evicts: assert property (
      acc_valid && acc_alias12 |=> cache_evict_en)
      else $error("alias access did not evict");
   a_forced_wt: assert property (
      dbg && !cache_ctrl[`CC_NO_WT] && acc_valid && acc_hit
      |=> cache_write_through)
      else $error("hit not write-through in debug state");
   a_icache_debug_ok: assert property (
      dbg && op_valid && op_code != debug_ext_pkg::OP_OTHER |=> op_accept)
      else $error("maintenance refused in debug state");
   a_apb_one_wait: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb ready not one cycle after wait");
   a_keep_power_wr: assert property (
      wr && paddr == `IDX_PWR_CTRL |=> keep_powered_out == $past(pwdata[0]))
      else $error("keep-powered output did not follow write");
   a_pd_ack: assert property (
      pd_req_s && core_idle |=> core_powerdown_ack)
      else $error("power-down acknowledge missing");

   c_ext_halt: cover property (state == debug_ext_pkg::HALTING ##[1:20] dbg);
   c_restart: cover property (dbg ##1 state == debug_ext_pkg::EXITING);
   c_slverr: cover property (pslverr);
   c_rx_set_clear: cover property (wr && paddr == `IDX_RX_DATA
      && core_rx_read);
endmodule

// ### debug_sync.sv
// two-flop synchroniser for the asynchronous debug inputs
`timescale 1ns/100ps
module debug_sync (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // levels in and out
   input wire logic [2:0] d,
   output logic [2:0] q
);
   logic [2:0] meta;
   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= 3'h0;
         q <= 3'h0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ### testbench.sv
// self-checking bench for the debug port block
`timescale 1ns/100ps
module testbench;
   // ****
   // signals and instances
   // ****
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel, penable, pwrite, access_source_bit, pready, pslverr;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, core_rx_data, core_tx_data, q;
   logic ext_halt_request, halt_acknowledge, core_halt_req, core_restart;
   logic core_in_debug, core_rx_read, core_tx_write, chan_rx_irq;
   logic chan_tx_irq, core_powerdown_request, core_idle, core_powerdown_ack;
   logic keep_powered_out, oslock_init_in, oslock, e, ok;
   logic acc_valid, acc_write, acc_hit, acc_alias12, acc_hash_match;
   logic cache_linefill_en, cache_evict_en;
   logic cache_write_through, cache_write_to_poc;
   logic op_valid, op_privileged, op_nonsecure, op_accept, op_undef;
   logic op_nop, op_flush_both;
   debug_ext_pkg::cache_op_t op_code;
   logic [3:0] exp_op [4] = '{4'h9, 4'h8, 4'ha, 4'h4};
   int bad_count = 0;
   int checks_done = 0;
   // straps stay fixed for the whole run
   debug_ext_port i_debug_ext_port (
      .rom_base_addr(20'habcde),
      .rom_base_valid(1'b1),
      .self_offset_addr(20'h12345),
      .self_offset_valid(1'b0),
      .*
   );
   dbg_host host (.*);
   always #5 clk = ~clk;
   // core model: halts on request, leaves on restart
   always @(posedge clk)
      core_in_debug <= reset_n
         && (core_halt_req || (core_in_debug && !core_restart));
   // ****
   // tasks
   // ****
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [9:0] a, input logic [31:0] d);
      host.xfer(w, a, d, q, e, ok);
      if (ok !== 1'b1) begin
         bad_count++;
         final_report();
      end
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task final_report();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      {core_rx_read, core_tx_write, core_idle, acc_valid} = 4'h0;
      {acc_write, acc_hit, acc_alias12, acc_hash_match} = 4'h0;
      {op_valid, op_privileged, op_nonsecure} = 3'h0;
      op_code = debug_ext_pkg::OP_OTHER;
      core_tx_data = 32'h0;
      oslock_init_in = 1'b1;
      tk(6);
      reset_n <= 1'b1;
      tk(4);
      chk(32'(oslock), 32'h1);
      chk(32'(chan_tx_irq), 32'h1);
      acc(0, 10'h007, 0);
      chk(q, 32'habcde001);
      acc(0, 10'h008, 0);
      chk(q, 32'h12345000);
      acc(0, 10'h00a, 0);
      chk(32'(e), 32'h1);
      // channel both ways
      acc(1, 10'h002, 32'h5a5a0001);
      chk(32'(chan_rx_irq), 32'h1);
      core_rx_read <= 1'b1;
      core_tx_write <= 1'b1;
      core_tx_data <= 32'hc3c30002;
      tk(1);
      core_rx_read <= 1'b0;
      core_tx_write <= 1'b0;
      tk(2);
      chk(32'({chan_rx_irq, chan_tx_irq}), 32'h0);
      chk(core_rx_data, 32'h5a5a0001);
      acc(0, 10'h003, 0);
      chk(q, 32'hc3c30002);
      tk(1);
      chk(32'(chan_tx_irq), 32'h1);
      // power handshake
      acc(1, 10'h004, 32'h1);
      host.pwr(1'b1);
      core_idle <= 1'b1;
      tk(5);
      chk(32'(keep_powered_out), 32'h1);
      chk(32'(core_powerdown_ack), 32'h1);
      acc(0, 10'h005, 0);
      chk(q, 32'h1);
      // external halt then debug-state cache policy
      host.halt(ok);
      chk(32'(ok), 32'h1);
      if (ok !== 1'b1) final_report();
      acc(0, 10'h000, 0);
      chk(q & 32'h8000003d, 32'h80000011);
      acc(1, 10'h001, 32'h0);
      {acc_valid, acc_write, acc_hit} <= 3'h7;
      tk(2);
      chk(32'({cache_linefill_en, cache_evict_en, cache_write_through,
         cache_write_to_poc}), 32'h3);
      acc_alias12 <= 1'b1;
      tk(2);
      chk(32'(cache_evict_en), 32'h1);
      acc_alias12 <= 1'b0;
      acc_hash_match <= 1'b1;
      tk(2);
      chk(32'(cache_evict_en), 32'h1);
      // unprivileged nonsecure maintenance while halted
      op_valid <= 1'b1;
      op_nonsecure <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         op_code <= debug_ext_pkg::cache_op_t'(i);
         tk(2);
         chk(32'({op_accept, op_undef, op_nop, op_flush_both}),
            32'(exp_op[i]));
      end
      // restart drops acknowledge, force bit raises it again
      acc(1, 10'h009, 32'h2);
      tk(6);
      chk(32'(halt_acknowledge), 32'h0);
      acc(1, 10'h000, 32'h400);
      tk(1);
      chk(32'(halt_acknowledge), 32'h1);
      final_report();
   end
endmodule
